// ===== include/pstbar_pkg.sv
package pstbar_pkg;

  // Configuration dword indices; byte offset is four times the index.
  localparam logic [5:0]  CFG_IDX_STATUS     = 6'h01;
  localparam logic [5:0]  CFG_IDX_CSR_MEM    = 6'h04;
  localparam logic [5:0]  CFG_IDX_CSR_IO     = 6'h05;
  localparam logic [5:0]  CFG_IDX_FLASH_MEM  = 6'h06;

  // Status field positions.
  localparam int          ST_BACK_TO_BACK    = 7;
  localparam int          ST_DATA_PARITY     = 8;
  localparam int          ST_SPEED_LO        = 9;
  localparam int          ST_SPEED_HI        = 10;
  localparam int          ST_SIG_TGT_ABORT   = 11;
  localparam int          ST_GOT_TGT_ABORT   = 12;
  localparam int          ST_GOT_MASTER_ABORT = 13;
  localparam int          ST_SIG_SYS_ERROR   = 14;
  localparam int          ST_DET_PARITY      = 15;

  // Bits that events set and writes of one clear.
  localparam logic [15:0] ST_EVENT_MASK      = 16'hf100;
  // Constant bits: back-to-back capable and medium select speed code.
  localparam logic [15:0] ST_FIXED_VALUE     = 16'h0280;
  localparam logic [15:0] ST_RESET_VALUE     = 16'h0000;
  localparam logic [1:0]  SELECT_SPEED_CODE  = 2'h1;

  // Window sizes as log2 of bytes.
  localparam int          CSR_MEM_SIZE_LOG2  = 12;
  localparam int          CSR_IO_SIZE_LOG2   = 5;
  localparam int          FLASH_SIZE_LOG2    = 20;

  // Read-only low nibble of each window base.
  localparam logic [3:0]  CSR_MEM_LOW        = 4'h8;
  localparam logic [3:0]  CSR_IO_LOW         = 4'h1;
  localparam logic [3:0]  FLASH_MEM_LOW      = 4'h0;
  localparam logic [31:0] BAR_RESET_VALUE    = 32'h0000_0000;

endpackage

// ===== design/pstbar_window.sv
`timescale 1ns/1ps
`default_nettype none

module pstbar_window #(
  parameter int         SIZE_LOG2 = 12,
  parameter logic [3:0] LOW_VALUE = 4'h0
) (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_nrst,
  // Configuration write
  input  wire logic        i_wr,
  input  wire logic [3:0]  i_be,
  input  wire logic [31:0] i_wdata,
  // Current base
  output logic      [31:0] o_value
);
  import pstbar_pkg::*;

  localparam logic [31:0] WRITABLE = ~((32'h0000_0001 << SIZE_LOG2) - 32'h0000_0001);

  logic [31:0] base;
  logic [31:0] lane_mask;

  always_comb begin
    lane_mask = {{8{i_be[3]}}, {8{i_be[2]}}, {8{i_be[1]}}, {8{i_be[0]}}} & WRITABLE;
  end

  // Bits below the window size never store, so sizing by all ones reads back the size.
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      base <= BAR_RESET_VALUE;
    end else if (i_wr) begin
      base <= (base & ~lane_mask) | (i_wdata & lane_mask); // [R17]
    end
  end

  always_comb begin
    o_value = base | {28'h000_0000, LOW_VALUE}; // [R12]
  end

endmodule // pstbar_window

`default_nettype wire

// ===== design/pstbar_top.sv
// Contract
// R1: Status reads plain; write one clears.
// R2: Status bits 0 to 6 read zero.
// R3: Status bit 7 reads one always.
// R4: Bit 8 on master PERR when enabled.
// R5: Select speed code fixed at medium.
// R6: Signaled target abort reads zero.
// R7: Bit 12 on received target abort.
// R8: Bit 13 on master abort, not special.
// R9: Bit 14 when SERR asserted.
// R10: Bit 15 on any parity error.
// R11: Three 32-bit window base registers.
// R12: Base bit 0: memory 0, I/O 1.
// R13: I/O base bit 1 reads zero.
// R14: Parity response disabled ignores parity errors.
// R15: I/O base requests 32 bytes.
// R16: Flash base requests 1 MB.
// R17: Bases writable only above window size.
`timescale 1ns/1ps
`default_nettype none

module pstbar_top (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_nrst,
  // Configuration access
  input  wire logic        i_cfg_rd,
  input  wire logic        i_cfg_wr,
  input  wire logic [5:0]  i_cfg_index,
  input  wire logic [3:0]  i_cfg_be,
  input  wire logic [31:0] i_cfg_wdata,
  output logic      [31:0] o_cfg_rdata,
  output logic             o_cfg_rvalid,
  // Command register input
  input  wire logic        i_parity_resp_en,
  // Bus events
  input  wire logic        i_perr_seen,
  input  wire logic        i_was_master,
  input  wire logic        i_target_abort_rcvd,
  input  wire logic        i_master_abort_rcvd,
  input  wire logic        i_special_cycle,
  input  wire logic        i_serr_asserted,
  input  wire logic        i_parity_err_detected,
  // Block state
  output logic      [15:0] o_status,
  output logic             o_parity_action,
  output logic      [31:0] o_csr_mem_base,
  output logic      [31:0] o_csr_io_base,
  output logic      [31:0] o_flash_base
);
  import pstbar_pkg::*;

  logic [15:0] status;
  logic [15:0] next_set;
  logic [15:0] next_clear;
  logic        wr_status;
  logic [31:0] csr_mem_value;
  logic [31:0] csr_io_value;
  logic [31:0] flash_value;

  always_comb begin
    wr_status = i_cfg_wr && (i_cfg_index == CFG_IDX_STATUS);
    next_clear = wr_status ? (i_cfg_wdata[31:16] & {{8{i_cfg_be[3]}}, {8{i_cfg_be[2]}}})
                           : 16'h0000; // [R1]
    next_set = 16'h0000;
    next_set[ST_DATA_PARITY] = i_perr_seen && i_was_master && i_parity_resp_en; // [R4]
    next_set[ST_GOT_TGT_ABORT] = i_target_abort_rcvd; // [R7]
    next_set[ST_GOT_MASTER_ABORT] = i_master_abort_rcvd && !i_special_cycle; // [R8]
    next_set[ST_SIG_SYS_ERROR] = i_serr_asserted; // [R9]
    next_set[ST_DET_PARITY] = i_parity_err_detected; // [R10]
  end

  // An event in the same cycle as its clear wins, so no event is lost.
  for (genvar b = 0; b < 16; b++) begin : g_status
    if (ST_EVENT_MASK[b]) begin : g_flag
      always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
          status[b] <= ST_RESET_VALUE[b];
        end else if (next_set[b]) begin
          status[b] <= 1'b1;
        end else if (next_clear[b]) begin
          status[b] <= 1'b0; // [R1]
        end
      end
    end else begin : g_fixed
      // A constant flop keeps every bit of status written by procedures alone.
      always_ff @(posedge i_clock) begin
        status[b] <= ST_FIXED_VALUE[b]; // [R2] [R3] [R5] [R6]
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_status <= ST_RESET_VALUE | ST_FIXED_VALUE;
    end else begin
      o_status <= status;
    end
  end

  // With response disabled a detected parity error is only recorded, never acted on.
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_parity_action <= 1'b0;
    end else begin
      o_parity_action <= i_parity_err_detected && i_parity_resp_en; // [R14]
    end
  end

  pstbar_window #(
    .SIZE_LOG2 (CSR_MEM_SIZE_LOG2),
    .LOW_VALUE (CSR_MEM_LOW)
  ) u_csr_mem (
    .i_clock (i_clock),
    .i_nrst  (i_nrst),
    .i_wr    (i_cfg_wr && (i_cfg_index == CFG_IDX_CSR_MEM)), // [R11]
    .i_be    (i_cfg_be),
    .i_wdata (i_cfg_wdata),
    .o_value (csr_mem_value)
  );

  pstbar_window #(
    .SIZE_LOG2 (CSR_IO_SIZE_LOG2),
    .LOW_VALUE (CSR_IO_LOW)
  ) u_csr_io (
    .i_clock (i_clock),
    .i_nrst  (i_nrst),
    .i_wr    (i_cfg_wr && (i_cfg_index == CFG_IDX_CSR_IO)), // [R11] [R13] [R15]
    .i_be    (i_cfg_be),
    .i_wdata (i_cfg_wdata),
    .o_value (csr_io_value)
  );

  pstbar_window #(
    .SIZE_LOG2 (FLASH_SIZE_LOG2),
    .LOW_VALUE (FLASH_MEM_LOW)
  ) u_flash_mem (
    .i_clock (i_clock),
    .i_nrst  (i_nrst),
    .i_wr    (i_cfg_wr && (i_cfg_index == CFG_IDX_FLASH_MEM)), // [R11] [R16]
    .i_be    (i_cfg_be),
    .i_wdata (i_cfg_wdata),
    .o_value (flash_value)
  );

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_csr_mem_base <= BAR_RESET_VALUE | {28'h000_0000, CSR_MEM_LOW};
      o_csr_io_base  <= BAR_RESET_VALUE | {28'h000_0000, CSR_IO_LOW};
      o_flash_base   <= BAR_RESET_VALUE | {28'h000_0000, FLASH_MEM_LOW};
    end else begin
      o_csr_mem_base <= csr_mem_value;
      o_csr_io_base  <= csr_io_value;
      o_flash_base   <= flash_value;
    end
  end

  // The read returns the value before any write in the same cycle; unmapped dwords read zero.
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_cfg_rdata  <= 32'h0000_0000;
      o_cfg_rvalid <= 1'b0;
    end else begin
      o_cfg_rvalid <= i_cfg_rd;
      if (i_cfg_rd) begin
        case (i_cfg_index)
          CFG_IDX_STATUS:    o_cfg_rdata <= {status, 16'h0000}; // [R1]
          CFG_IDX_CSR_MEM:   o_cfg_rdata <= csr_mem_value;
          CFG_IDX_CSR_IO:    o_cfg_rdata <= csr_io_value;
          CFG_IDX_FLASH_MEM: o_cfg_rdata <= flash_value;
          default:           o_cfg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  sequence s_io_all_ones;
    i_cfg_wr && (i_cfg_index == CFG_IDX_CSR_IO) && (i_cfg_be == 4'hf)
      && (i_cfg_wdata == 32'hffff_ffff);
  endsequence

  sequence s_io_read;
    i_cfg_rd && (i_cfg_index == CFG_IDX_CSR_IO) && !i_cfg_wr;
  endsequence

  property p_fixed_bits;
    o_status[7:0] == 8'h80 && o_status[ST_SPEED_HI:ST_SPEED_LO] == SELECT_SPEED_CODE
      && !o_status[ST_SIG_TGT_ABORT];
  endproperty
  a_fixed_bits: assert property (p_fixed_bits) else $error("fixed status bits wrong"); // [R2]

  property p_data_parity_cause;
    $rose(status[ST_DATA_PARITY]) |-> $past(i_perr_seen && i_was_master && i_parity_resp_en);
  endproperty
  a_data_parity_cause: assert property (p_data_parity_cause)
    else $error("bit 8 set without cause"); // [R4]

  property p_target_abort;
    i_target_abort_rcvd |=> status[ST_GOT_TGT_ABORT] ##1 o_status[ST_GOT_TGT_ABORT];
  endproperty
  a_target_abort: assert property (p_target_abort) else $error("bit 12 not set"); // [R7]

  property p_master_abort;
    $rose(status[ST_GOT_MASTER_ABORT]) |-> $past(i_master_abort_rcvd && !i_special_cycle);
  endproperty
  a_master_abort: assert property (p_master_abort) else $error("bit 13 bad set"); // [R8]

  property p_serr_wins;
    i_serr_asserted && wr_status && i_cfg_be[3] && i_cfg_wdata[30] |=> status[ST_SIG_SYS_ERROR];
  endproperty
  a_serr_wins: assert property (p_serr_wins) else $error("bit 14 event lost"); // [R9]

  property p_write_clears;
    wr_status && i_cfg_be[3] && i_cfg_wdata[31] && !i_parity_err_detected
      |=> !status[ST_DET_PARITY];
  endproperty
  a_write_clears: assert property (p_write_clears) else $error("bit 15 not cleared"); // [R1]

  property p_parity_always;
    i_parity_err_detected && !i_parity_resp_en |=> status[ST_DET_PARITY] && !o_parity_action;
  endproperty
  a_parity_always: assert property (p_parity_always) else $error("bit 15 or action wrong"); // [R10]

  property p_io_sizing;
    s_io_all_ones ##1 s_io_read |=> o_cfg_rdata == 32'hffff_ffe1 && o_cfg_rvalid;
  endproperty
  a_io_sizing: assert property (p_io_sizing) else $error("I/O base sizing wrong"); // [R15]

  property p_low_bits;
    o_csr_mem_base[3:0] == CSR_MEM_LOW && o_csr_io_base[1:0] == 2'h1
      && o_flash_base[19:0] == 20'h0_0000;
  endproperty
  a_low_bits: assert property (p_low_bits) else $error("base low bits wrong"); // [R12]

endmodule // pstbar_top

`default_nettype wire

// ===== test/pstbar_host.sv
`timescale 1ns/1ps
`default_nettype none

module pstbar_host (
  // Clock
  input  wire logic        i_clock,
  // Answer from the device
  input  wire logic [31:0] i_rdata,
  input  wire logic        i_rvalid,
  // Configuration requests
  output logic             o_rd,
  output logic             o_wr,
  output logic      [5:0]  o_index,
  output logic      [3:0]  o_be,
  output logic      [31:0] o_wdata
);
  initial begin
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_index = 6'h00;
    o_be = 4'h0;
    o_wdata = 32'h0;
  end

  // Released byte enables and data are scrambled so that stale values are never mistaken for live ones.
  task automatic wr(input logic [5:0] k, input logic [3:0] b, input logic [31:0] d);
    @(posedge i_clock);
    o_wr <= 1'b1;
    o_index <= k;
    o_be <= b;
    o_wdata <= d;
    @(posedge i_clock);
    o_wr <= 1'b0;
    o_be <= ~b;
    o_wdata <= ~d;
  endtask

  // A write followed at once by a read of the same dword, with no idle cycle between.
  task automatic wr_rd(input logic [5:0] k, input logic [3:0] b, input logic [31:0] d,
                       output logic [31:0] q);
    @(posedge i_clock);
    o_wr <= 1'b1;
    o_index <= k;
    o_be <= b;
    o_wdata <= d;
    @(posedge i_clock);
    o_wr <= 1'b0;
    o_rd <= 1'b1;
    o_be <= ~b;
    o_wdata <= ~d;
    @(posedge i_clock);
    o_rd <= 1'b0;
    o_index <= ~k;
    @(negedge i_clock);
    q = (i_rvalid === 1'b1) ? i_rdata : 32'hxxxx_xxxx;
  endtask

  // A missing answer returns unknowns, so the comparison that follows fails.
  task automatic rd(input logic [5:0] k, output logic [31:0] d);
    @(posedge i_clock);
    o_rd <= 1'b1;
    o_index <= k;
    @(posedge i_clock);
    o_rd <= 1'b0;
    o_index <= ~k;
    @(negedge i_clock);
    d = (i_rvalid === 1'b1) ? i_rdata : 32'hxxxx_xxxx;
  endtask
endmodule // pstbar_host

`default_nettype wire

// ===== test/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import pstbar_pkg::*;
  logic        i_clock = 1'b0;
  logic        i_nrst = 1'b0;
  logic        pen = 1'b0;
  logic [6:0]  ev = 7'h00;
  logic        rd, wr, rv, pact;
  logic [5:0]  idx;
  logic [3:0]  be;
  logic [31:0] wd, rdat, b0, b1, b2, r, got;
  logic [15:0] st, m_st;
  logic [31:0] m_b [3];
  logic [31:0] msk [3] = '{32'hffff_f000, 32'hffff_ffe0, 32'hfff0_0000};
  logic [31:0] lo [3] = '{{28'h0, CSR_MEM_LOW}, {28'h0, CSR_IO_LOW}, {28'h0, FLASH_MEM_LOW}};
  integer      seed = 34460;
  integer      errors = 0;
  integer      total_checks = 0;

  always #12.5 i_clock = ~i_clock;

  pstbar_host host_u (.i_clock(i_clock), .i_rdata(rdat), .i_rvalid(rv), .o_rd(rd),
    .o_wr(wr), .o_index(idx), .o_be(be), .o_wdata(wd));

  pstbar_top dut_u (.i_clock(i_clock), .i_nrst(i_nrst), .i_cfg_rd(rd), .i_cfg_wr(wr),
    .i_cfg_index(idx), .i_cfg_be(be), .i_cfg_wdata(wd), .o_cfg_rdata(rdat),
    .o_cfg_rvalid(rv), .i_parity_resp_en(pen), .i_perr_seen(ev[0]), .i_was_master(ev[1]),
    .i_target_abort_rcvd(ev[2]), .i_master_abort_rcvd(ev[3]), .i_special_cycle(ev[4]),
    .i_serr_asserted(ev[5]), .i_parity_err_detected(ev[6]), .o_status(st),
    .o_parity_action(pact), .o_csr_mem_base(b0), .o_csr_io_base(b1), .o_flash_base(b2));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("checks %0d, errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Aborts only come back on our own transactions, and a seen error is a detected one.
  task automatic pulse(input logic [31:0] v);
    logic [6:0] e;
    e = v[6:0];
    e[2] = e[2] & e[1];
    e[3] = e[3] & e[1];
    e[6] = e[6] | e[0];
    @(posedge i_clock);
    ev <= e;
    pen <= v[7];
    @(posedge i_clock);
    ev <= 7'h00;
    m_st |= {e[6], e[5], e[3] & ~e[4], e[2], 3'h0, e[0] & e[1] & v[7], 8'h0};
    @(negedge i_clock);
    check({31'h0, pact}, {31'h0, e[6] & v[7]});
  endtask

  task automatic st_rd;
    host_u.rd(6'h01, got);
    check(got, {m_st, 16'h0});
    check({16'h0, st}, {16'h0, m_st});
  endtask

  task automatic st_wr(input logic [3:0] b, input logic [31:0] d);
    host_u.wr(6'h01, b, d);
    m_st &= ~(d[31:16] & {{8{b[3]}}, {8{b[2]}}} & 16'hf100);
    st_rd();
  endtask

  task automatic bar_wr(input int k, input logic [3:0] b, input logic [31:0] d);
    host_u.wr(6'h04 + k[5:0], b, d);
    for (int l = 0; l < 4; l++) begin
      if (b[l]) m_b[k][8*l+:8] = d[8*l+:8];
    end
    m_b[k] = (m_b[k] & msk[k]) | lo[k];
    host_u.rd(6'h04 + k[5:0], got);
    check(got, m_b[k]);
    check(k == 0 ? b0 : k == 1 ? b1 : b2, m_b[k]);
  endtask

  initial begin
    m_st = 16'h0280;
    m_b = lo;
    repeat (5) @(posedge i_clock);
    i_nrst <= 1'b1;
    st_rd();
    for (int k = 0; k < 3; k++) begin
      bar_wr(k, 4'h0, 32'h0);
      bar_wr(k, 4'hf, 32'hffff_ffff);
    end
    host_u.wr(6'h07, 4'hf, 32'hffff_ffff);
    host_u.rd(6'h07, got);
    check(got, 32'h0);
    host_u.wr_rd(6'h05, 4'hf, 32'hffff_ffff, got);
    m_b[1] = 32'hffff_ffe1;
    check(got, m_b[1]);
    fork
      host_u.wr(6'h01, 4'hf, 32'h4000_0000);
      begin
        @(posedge i_clock);
        ev <= 7'h20;
        @(posedge i_clock);
        ev <= 7'h00;
      end
    join
    m_st[ST_SIG_SYS_ERROR] = 1'b1;
    st_rd();
    st_wr(4'hf, 32'h4000_0000);
    for (int n = 0; n < 80; n++) begin
      r = $random(seed);
      pulse(r);
      if (r[8]) st_wr(r[12:9], $random(seed));
      else st_rd();
      bar_wr(r[14:13] % 3, r[18:15], $random(seed));
    end
    conclude();
  end

  initial begin
    #(25 * 8000);
    errors++;
    conclude();
  end
endmodule // testbench

`default_nettype wire
